// ### hw/cac_device.sv
// Control logic of the clock amplifier module: registers, serial loads, edge counters
`timescale 1ns/1ps
`default_nettype none
module cac_device
  import cac_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01  // Arbitrary revision value
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  cac_link_if.device bus
);
  ////////////////////////////////////////////////////////////////////////////
  logic [GAIN_W-1:0] gain_ff [6];
  logic [SINE_N-1:0] sine_on_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [2:0] pend_ff;  // Pending atten loads
  logic pend_adc_ff;
  logic pend_exp_ff;
  logic exp_cfg_ff;  // Pending expander word is config
  logic [7:0] mon_ctrl_ff;
  logic [SQ_N-1:0] sq_en_ff;
  logic [ADC_W-1:0] adc_ff;
  logic [CNT_W-1:0] cnt_ff [SQ_N];
  logic [CNT_W-1:0] held_ff [SQ_N];
  logic [SQ_N-1:0] s1_ff, s2_ff, s3_ff;
  logic [9:0] win_ff;
  cac_state_t state_ff;
  cac_tgt_t tgt_ff;
  logic [1:0] atten_idx_ff;
  logic [EXP_W-1:0] sh_ff;
  logic [ADC_W-1:0] rx_ff;
  logic [4:0] bits_ff;
  logic [3:0] div_ff;
  logic sclk_ff, sdo_ff, adc_sel_ff, exp_sel_ff;
  logic [2:0] atten_sel_ff;
  logic sdi_s1_ff, sdi_s2_ff;
  logic wr_hit;
  logic [1:0] pick;

  assign wr_hit = bus.wr;

  ////////////////////////////////////////////////////////////////////////////
  // Gain and enable storage; each gain written alone keeps pair independent
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < 6; i++)
        gain_ff[i] <= '0;
      sine_on_ff <= '0;
      mon_ctrl_ff <= REG_RESET;
      sq_en_ff <= '0;
    end
    else if (wr_hit)
    begin
      for (int i = 0; i < 6; i++)
        if (bus.addr == OFF_SINE1_GAIN + 8'(2 * i))
          gain_ff[i] <= bus.wdata[GAIN_W-1:0];
      if (bus.addr == OFF_SINE_ENABLES)
        sine_on_ff <= bus.wdata[SINE_N-1:0];
      if (bus.addr == OFF_MON_CTRL)
        mon_ctrl_ff <= {1'b0, ADC_CTRL_B6, bus.wdata[5:3], ADC_CTRL_TAIL};
      if (bus.addr == OFF_SQ_ENABLES)
        sq_en_ff <= bus.wdata[SQ_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger requests; a set in the same cycle as service wins
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pend_ff <= '0;
      pend_adc_ff <= 1'b0;
      pend_exp_ff <= 1'b0;
      exp_cfg_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == CAC_LOAD)
      begin
        if (tgt_ff == CAC_TGT_ATTEN)
          pend_ff[atten_idx_ff] <= 1'b0;
        if (tgt_ff == CAC_TGT_ADC)
          pend_adc_ff <= 1'b0;
        if (tgt_ff == CAC_TGT_EXP)
          pend_exp_ff <= 1'b0;
      end
      if (wr_hit && bus.addr == OFF_SINE2_GAIN)
        pend_ff[0] <= 1'b1;
      if (wr_hit && bus.addr == OFF_SINE4_GAIN)
        pend_ff[1] <= 1'b1;
      if (wr_hit && bus.addr == OFF_SINE_IN_GAIN)
        pend_ff[2] <= 1'b1;
      if (wr_hit && bus.addr == OFF_MON_CTRL)
        pend_adc_ff <= 1'b1;
      if (wr_hit && (bus.addr == OFF_SQ_CONFIG || bus.addr == OFF_SQ_ENABLES))
      begin
        pend_exp_ff <= 1'b1;
        exp_cfg_ff <= (bus.addr == OFF_SQ_CONFIG);
      end
    end
  end

  // Lowest pending attenuator wins
  assign pick = pend_ff[0] ? 2'd0 : (pend_ff[1] ? 2'd1 : 2'd2);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock divider: one enable every half period
  always_ff @(posedge i_clk)
  begin
    if (i_reset || state_ff != CAC_SHIFT)
      div_ff <= '0;
    else if (div_ff == 4'(SCLK_HALF_CYC - 1))
      div_ff <= '0;
    else
      div_ff <= div_ff + 4'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine, MSB first, select held across the whole word
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_ff <= CAC_IDLE;
      tgt_ff <= CAC_TGT_ATTEN;
      atten_idx_ff <= '0;
      sh_ff <= '0;
      rx_ff <= '0;
      bits_ff <= '0;
      sclk_ff <= 1'b0;
      sdo_ff <= 1'b0;
      atten_sel_ff <= 3'h7;
      adc_sel_ff <= 1'b1;
      exp_sel_ff <= 1'b1;
      adc_ff <= '0;
    end
    else
    begin
      case (state_ff)
        CAC_IDLE:
        begin
          if (pend_ff != 3'h0)
          begin
            tgt_ff <= CAC_TGT_ATTEN;
            atten_idx_ff <= pick;
            sh_ff <= {4'h0, gain_ff[2*pick+1], gain_ff[2*pick]};
            bits_ff <= 5'(ATTEN_W);
            state_ff <= CAC_LOAD;
          end
          else if (pend_adc_ff)
          begin
            tgt_ff <= CAC_TGT_ADC;
            // Control byte sits where the 4-bit align shift puts it on top
            sh_ff <= {4'h0, mon_ctrl_ff, 4'h0};
            bits_ff <= 5'(ATTEN_W);
            state_ff <= CAC_LOAD;
          end
          else if (pend_exp_ff)
          begin
            tgt_ff <= CAC_TGT_EXP;
            sh_ff <= exp_cfg_ff ? {EXP_REG_CONFIG, EXP_ALL_OUTPUTS}
                                : {EXP_REG_OUTPUT, 4'h0, sq_en_ff};
            bits_ff <= 5'(EXP_W);
            state_ff <= CAC_LOAD;
          end
        end
        CAC_LOAD:
        begin
          // Align first bit to the top of the shifter
          if (tgt_ff != CAC_TGT_EXP)
            sh_ff <= sh_ff << 4;
          // First bit settles a half period before the first rising clock
          sdo_ff <= (tgt_ff != CAC_TGT_EXP) ? sh_ff[ATTEN_W-1] : sh_ff[EXP_W-1];
          case (tgt_ff)
            CAC_TGT_ATTEN: atten_sel_ff[atten_idx_ff] <= 1'b0;
            CAC_TGT_ADC: adc_sel_ff <= 1'b0;
            default: exp_sel_ff <= 1'b0;
          endcase
          state_ff <= CAC_SHIFT;
        end
        CAC_SHIFT:
        begin
          if (div_ff == 4'(SCLK_HALF_CYC - 1))
          begin
            if (!sclk_ff)
            begin
              // Data never changes on the rising edge the peripheral samples
              if (bits_ff == 5'd0)
                state_ff <= CAC_DONE;
              else
                sclk_ff <= 1'b1;
            end
            else
            begin
              sclk_ff <= 1'b0;
              sdo_ff <= sh_ff[EXP_W-2];
              sh_ff <= sh_ff << 1;
              rx_ff <= {rx_ff[ADC_W-2:0], sdi_s2_ff};
              bits_ff <= bits_ff - 5'd1;
            end
          end
        end
        CAC_DONE:
        begin
          atten_sel_ff <= 3'h7;
          adc_sel_ff <= 1'b1;
          exp_sel_ff <= 1'b1;
          if (tgt_ff == CAC_TGT_ADC)
            adc_ff <= rx_ff;
          state_ff <= CAC_IDLE;
        end
        default: state_ff <= CAC_IDLE;
      endcase
    end
  end

  // Returning ADC data arrives from off chip
  always_ff @(posedge i_clk)
  begin
    sdi_s1_ff <= bus.sdi;
    sdi_s2_ff <= sdi_s1_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Square inputs: three stages, edge when second is high and third low
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= bus.square_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Window counter; edge counts latch and restart at window end
  always_ff @(posedge i_clk)
  begin
    if (i_reset || win_ff == 10'(WINDOW_CYC - 1))
      win_ff <= '0;
    else
      win_ff <= win_ff + 10'd1;
  end

  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < SQ_N; i++)
    begin
      if (i_reset)
      begin
        cnt_ff[i] <= '0;
        held_ff[i] <= '0;
      end
      else if (win_ff == 10'(WINDOW_CYC - 1))
      begin
        // Edge in the last cycle counts toward the latched value
        held_ff[i] <= cnt_ff[i] + CNT_W'(s2_ff[i] & ~s3_ff[i]);
        cnt_ff[i] <= '0;
      end
      else if (s2_ff[i] && !s3_ff[i])
        cnt_ff[i] <= cnt_ff[i] + 4'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped and write-only offsets read zero
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= bus.rd;
      case (bus.addr)
        OFF_REVISION: rdata_ff <= REVISION;
        OFF_SQ_PAIR_A: rdata_ff <= {held_ff[1], held_ff[0]};
        OFF_SQ_PAIR_B: rdata_ff <= {held_ff[3], held_ff[2]};
        OFF_MON_LOW: rdata_ff <= adc_ff[7:0];
        OFF_MON_HIGH: rdata_ff <= {4'h0, adc_ff[11:8]};
        default: rdata_ff <= '0;
      endcase
    end
  end

  assign bus.rdata = rdata_ff;
  assign bus.rvalid = rvalid_ff;
  assign bus.sclk = sclk_ff;
  assign bus.sdo = sdo_ff;
  assign bus.atten_sel_n = atten_sel_ff;
  assign bus.adc_sel_n = adc_sel_ff;
  assign bus.exp_sel_n = exp_sel_ff;
  assign bus.sine_on = sine_on_ff;
endmodule
`default_nettype wire

// ### hw/cac_host.sv
// Carrier end: turns user requests into paced register bus cycles
`timescale 1ns/1ps
`default_nettype none
module cac_host
  import cac_pkg::*;
#(
  parameter int GAP_NS = 30000
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  cac_link_if.host bus
);
  // Longest wait covers expander spacing, ADC and attenuator waits
  localparam int GAP_CYC = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  logic [7:0] addr_ff, wdata_ff, rdata_ff;
  logic wr_ff, rd_ff, busy_ff, done_ff;
  logic [15:0] gap_ff;

  ////////////////////////////////////////////////////////////////////////////
  // One access, then a fixed quiet time before the next
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      addr_ff <= '0;
      wdata_ff <= '0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= '0;
      gap_ff <= '0;
    end
    else
    begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      done_ff <= 1'b0;
      if (bus.rvalid)
        rdata_ff <= bus.rdata;
      if (!busy_ff && i_req)
      begin
        addr_ff <= i_addr;
        wdata_ff <= i_wdata;
        wr_ff <= i_write;
        rd_ff <= !i_write;
        busy_ff <= 1'b1;
        gap_ff <= 16'(GAP_CYC);
      end
      else if (busy_ff)
      begin
        if (gap_ff == 16'd0)
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
          gap_ff <= gap_ff - 16'd1;
      end
    end
  end

  assign bus.addr = addr_ff;
  assign bus.wdata = wdata_ff;
  assign bus.wr = wr_ff;
  assign bus.rd = rd_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// ### hw/cac_link_if.sv
// Interface joining the register bus and the serial peripheral pins of the block
`timescale 1ns/1ps
`default_nettype none
interface cac_link_if;
  // Register bus: carrier drives address, data and strobes; device returns read data
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;
  // Serial peripheral pins; the block drives all but the returning sdi
  logic sclk;
  logic sdo;
  logic [2:0] atten_sel_n;
  logic adc_sel_n;
  logic exp_sel_n;
  logic sdi;
  // Sensed and controlled outputs
  logic [4:0] sine_on;
  logic [3:0] square_in;
  modport device (
    input addr, wdata, wr, rd, sdi, square_in,
    output rdata, rvalid, sclk, sdo, atten_sel_n, adc_sel_n, exp_sel_n, sine_on
  );
  modport host (
    output addr, wdata, wr, rd,
    input rdata, rvalid
  );
endinterface
`default_nettype wire

// ### hw/cac_pkg.sv
// Package of register map, field layout and timing constants for the clock amplifier control
package cac_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_REVISION = 8'h00;
  localparam logic [7:0] OFF_SINE1_GAIN = 8'h02;
  localparam logic [7:0] OFF_SINE2_GAIN = 8'h04;
  localparam logic [7:0] OFF_SINE3_GAIN = 8'h06;
  localparam logic [7:0] OFF_SINE4_GAIN = 8'h08;
  localparam logic [7:0] OFF_SINE5_GAIN = 8'h0a;
  localparam logic [7:0] OFF_SINE_IN_GAIN = 8'h0c;
  localparam logic [7:0] OFF_SQ_CONFIG = 8'h0e;
  localparam logic [7:0] OFF_SQ_ENABLES = 8'h10;
  localparam logic [7:0] OFF_SINE_ENABLES = 8'h12;
  localparam logic [7:0] OFF_SQ_PAIR_A = 8'h14;
  localparam logic [7:0] OFF_SQ_PAIR_B = 8'h16;
  localparam logic [7:0] OFF_MON_CTRL = 8'h18;
  localparam logic [7:0] OFF_MON_LOW = 8'h1a;
  localparam logic [7:0] OFF_MON_HIGH = 8'h1c;
  // Field widths
  localparam int GAIN_W = 6;
  localparam int ATTEN_W = 12;
  localparam int SINE_N = 5;
  localparam int SQ_N = 4;
  localparam int CNT_W = 4;
  localparam int ADC_W = 12;
  localparam int EXP_W = 16;
  // ADC control byte fixed fields
  localparam logic [2:0] ADC_CTRL_TAIL = 3'h4;
  localparam logic ADC_CTRL_B6 = 1'b0;
  // Expander words: register select byte then value byte
  localparam logic [7:0] EXP_REG_CONFIG = 8'h03;
  localparam logic [7:0] EXP_REG_OUTPUT = 8'h01;
  localparam logic [7:0] EXP_ALL_OUTPUTS = 8'h00;
  // Reset value of write registers
  localparam logic [7:0] REG_RESET = 8'h00;
  // Timing: clock 50 MHz, window 1 us, serial clock 5 MHz
  localparam int CLK_HZ = 50_000_000;
  localparam int WINDOW_NS = 1000;
  localparam int WINDOW_CYC = (WINDOW_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SCLK_HALF_CYC = 5;
  // Serial engine states and transfer targets
  typedef enum logic [3:0] {
    CAC_IDLE = 4'b0001,
    CAC_LOAD = 4'b0010,
    CAC_SHIFT = 4'b0100,
    CAC_DONE = 4'b1000
  } cac_state_t;
  typedef enum logic [1:0] {
    CAC_TGT_ATTEN = 2'h0,
    CAC_TGT_ADC = 2'h1,
    CAC_TGT_EXP = 2'h2
  } cac_tgt_t;
endpackage

// ### test/cac_asserts.sv
// Checker on the link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module cac_asserts
  import cac_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic sclk,
  input wire logic [2:0] atten_sel_n,
  input wire logic adc_sel_n,
  input wire logic exp_sel_n,
  input wire logic [4:0] sine_on
);
  ////////////////////////////////////////////////////////////////////////
  // All serial selects released
  logic idle;
  assign idle = &atten_sel_n & adc_sel_n & exp_sel_n;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////////////////
  // Register answers
  read_answer_a: assert property (rd |=> rvalid)
    else $error("read got no answer");
  rev_value_a: assert property (rd && addr == OFF_REVISION |=> rdata == REVISION)
    else $error("revision value wrong");
  wo_zero_a: assert property (rd && addr == OFF_SINE_ENABLES |=> rdata == 8'h00)
    else $error("write-only place read nonzero");
  sine_en_a: assert property (wr && addr == OFF_SINE_ENABLES |=> {3'h0, sine_on} == ($past(wdata) & 8'h1f))
    else $error("sine enables not taken");
  // Triggers must reach their select; bound covers queued transfers
  pair1_go_a: assert property (wr && addr == OFF_SINE2_GAIN |-> ##[1:1000] $fell(atten_sel_n[0]))
    else $error("pair one load missing");
  pair2_go_a: assert property (wr && addr == OFF_SINE4_GAIN |-> ##[1:1000] $fell(atten_sel_n[1]))
    else $error("pair two load missing");
  pair3_go_a: assert property (wr && addr == OFF_SINE_IN_GAIN |-> ##[1:1000] $fell(atten_sel_n[2]))
    else $error("pair three load missing");
  adc_go_a: assert property (wr && addr == OFF_MON_CTRL |-> ##[1:1000] $fell(adc_sel_n))
    else $error("converter exchange missing");
  exp_go_a: assert property (wr && (addr == OFF_SQ_CONFIG || addr == OFF_SQ_ENABLES) |-> ##[1:1000] $fell(exp_sel_n))
    else $error("expander transfer missing");
  ////////////////////////////////////////////////////////////////////////
  // Serial framing
  one_sel_a: assert property ($onehot0({~atten_sel_n, ~adc_sel_n, ~exp_sel_n}))
    else $error("two selects low");
  sel_hold_a: assert property ($fell(idle) |-> !idle [*8])
    else $error("select dropped early");
  sclk_rest_a: assert property (idle && $past(idle) |-> !sclk)
    else $error("serial clock runs outside frame");
  cover property (rd && addr == OFF_MON_LOW);
  cover property ($fell(adc_sel_n));
  cover property ($fell(exp_sel_n));
endmodule
`default_nettype wire

// ### test/clock_amp_register_control_tb.sv
// Testbench joining host and device ends of the clock amplifier control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module clock_amp_register_control_tb
  import cac_pkg::*;
;
  logic i_clk, i_reset, i_req, i_write, o_busy, o_done, sq_a, sq_b, idle;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [15:0] sh, word;
  logic [11:0] adc_val;
  logic [4:0] sel_at;
  int nb, nbits, n_mismatch, compares;
  cac_link_if link();
  assign idle = &link.atten_sel_n & link.adc_sel_n & link.exp_sel_n;
  assign link.square_in = {~sq_a, 1'b0, sq_b, sq_a};
  // Revision value is arbitrary
  cac_device #(.REVISION(8'h3c)) i_cac_device (.i_clk(i_clk), .i_reset(i_reset), .bus(link.device));
  // Full host gap keeps every pacing duty of the carrier
  cac_host #(.GAP_NS(30000)) i_cac_host (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req),
    .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
    .o_rdata(o_rdata), .bus(link.host));
  cac_asserts #(.REVISION(8'h3c)) i_cac_asserts (.i_clk(i_clk), .i_reset(i_reset),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .rvalid(link.rvalid), .sclk(link.sclk), .atten_sel_n(link.atten_sel_n),
    .adc_sel_n(link.adc_sel_n), .exp_sel_n(link.exp_sel_n), .sine_on(link.sine_on));
  ////////////////////////////////////////////////////////////////////////
  // Clock and free running square waves of 10 and 5 MHz
  initial
  begin
    i_clk = 0;
    forever #10 i_clk = ~i_clk;
  end
  initial
  begin
    sq_a = 0;
    forever #50 sq_a = ~sq_a;
  end
  initial
  begin
    sq_b = 0;
    forever #100 sq_b = ~sq_b;
  end
  ////////////////////////////////////////////////////////////////////////
  // Frame start: clear capture, converter puts out its first bit
  always @(negedge idle)
  begin
    sh = 0;
    nb = 0;
    sel_at = {link.atten_sel_n, link.adc_sel_n, link.exp_sel_n};
    link.sdi = adc_val[11];
  end
  // Capture on rising serial clock; next converter bit after the falling sample
  always @(posedge link.sclk)
  begin
    sh = {sh[14:0], link.sdo};
    nb++;
    if (nb >= 2 && nb <= 12)
      link.sdi = adc_val[12 - nb];
  end
  // Frame end: keep word; released line must not keep its value
  always @(posedge idle)
  begin
    word = sh;
    nbits = nb;
    link.sdi = ~link.sdi;
  end
  ////////////////////////////////////////////////////////////////////////
  // One paced carrier access, bounded waits
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge i_clk);
    for (k = 0; o_busy !== 1'b0 && k < 3000; k++) @(negedge i_clk);
    i_req = 1;
    i_write = w;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    i_req = 0;
    for (k = 0; o_done !== 1'b1 && k < 3000; k++) @(negedge i_clk);
    if (k >= 3000) n_mismatch++;
  endtask
  task automatic t_regs();
    op(0, OFF_REVISION, 8'h00);
    `CHK("revision", 8'h3c, o_rdata)
    op(1, OFF_SINE_ENABLES, 8'he9);
    `CHK("sine on", 5'h09, link.sine_on)
    op(0, OFF_SINE_ENABLES, 8'h00);
    `CHK("write-only read", 8'h00, o_rdata)
  endtask
  // Each pair, then one half rewritten alone
  task automatic t_gains();
    logic [7:0] lo [3] = '{OFF_SINE1_GAIN, OFF_SINE3_GAIN, OFF_SINE5_GAIN};
    logic [7:0] hi [3] = '{OFF_SINE2_GAIN, OFF_SINE4_GAIN, OFF_SINE_IN_GAIN};
    for (int i = 0; i < 3; i++)
    begin
      op(1, lo[i], {2'b11, 6'h2a ^ 6'(i)});
      op(1, hi[i], {2'b10, 6'h15 + 6'(i)});
      `CHK("gain word", {4'h0, 6'h15 + 6'(i), 6'h2a ^ 6'(i)}, word)
      `CHK("gain select", 5'h1f ^ (5'h04 << i), sel_at)
      `CHK("gain bits", ATTEN_W, nbits)
    end
    op(1, OFF_SINE2_GAIN, 8'h3f);
    `CHK("gain kept", 16'h0fea, word)
  endtask
  task automatic t_expander();
    op(1, OFF_SQ_CONFIG, 8'h5a);
    `CHK("config word", {EXP_REG_CONFIG, EXP_ALL_OUTPUTS}, word)
    `CHK("config bits", EXP_W, nbits)
    op(1, OFF_SQ_ENABLES, 8'hf6);
    `CHK("enable word", {EXP_REG_OUTPUT, 8'h06}, word)
    `CHK("expander select", 5'h1e, sel_at)
  endtask
  // Fixed fields written wrong on purpose
  task automatic t_adc();
    adc_val = 12'ha5c;
    op(1, OFF_MON_CTRL, 8'heb);
    `CHK("adc control", {ADC_CTRL_B6, 3'h5, ADC_CTRL_TAIL, 4'h0}, word[10:0])
    `CHK("adc select", 5'h1d, sel_at)
    op(0, OFF_MON_LOW, 8'h00);
    `CHK("adc low", 8'h5c, o_rdata)
    op(0, OFF_MON_HIGH, 8'h00);
    `CHK("adc high", 8'h0a, o_rdata)
  endtask
  task automatic t_square();
    op(0, OFF_SQ_PAIR_A, 8'h00);
    `CHK("square1", 1'b1, o_rdata[3:0] inside {4'h9, 4'ha, 4'hb})
    `CHK("square2", 1'b1, o_rdata[7:4] inside {4'h4, 4'h5, 4'h6})
    op(0, OFF_SQ_PAIR_B, 8'h00);
    `CHK("square3", 4'h0, o_rdata[3:0])
    `CHK("square4", 1'b1, o_rdata[7:4] inside {4'h9, 4'ha, 4'hb})
  endtask
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond about 25500 expected cycles
  initial
  begin
    #1_000_000;
    n_mismatch++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    {i_reset, i_req, i_write, i_addr, i_wdata, adc_val} = {3'h4, 28'h0};
    {n_mismatch, compares, link.sdi} = 0;
    repeat (5) @(negedge i_clk);
    i_reset = 0;
    `CHK("reset sine on", 5'h00, link.sine_on)
    `CHK("reset idle", 1'b1, idle)
    t_regs();
    t_gains();
    t_expander();
    t_adc();
    t_square();
    complete_run();
  end
endmodule
`default_nettype wire
